// ==== design/iommu_cr2_bypass_attr_regs.v ====
// What this block does
// [RULE1] private_maintenance 1 lets broadcast invalidations be skipped; 0 means participate
// [RULE2] bad_stream_id_recording 0 suppresses bad stream events; 1 permits recording
// [RULE3] recording setting only applies to transactions received while translation enabled
// [RULE4] host_extension_select picks untagged or address-space tagged hypervisor regime
// [RULE5] software invalidates hypervisor entries after changing host_extension_select
// [RULE6] control_two becomes read-only once enable update to 1 completes
// [RULE7] control_two write during enable update may apply or be ignored
// [RULE8] new control_two value takes effect by next enable update to 1
// [RULE9] broadcast invalidations after enable use the latched private_maintenance
// [RULE10] host_extension change sequence: disable, write, invalidate, sync, re-enable
// [RULE11] bypass register written whole with update flag; device clears flag when done
// [RULE12] abort bit aborts all transactions; else bypass with override attributes; here secure transactions are not aborted, they are translated
// [RULE13] instruction and privilege overrides: 00/01 keep, 10 low, 11 high; writes data
// [RULE14] shareability override: 00 non, 01 keep, 10 outer, 11 inner
// [RULE15] allocation override top bit 1 forces read, write, transient hints
// [RULE16] allocation override acts only on normal write-back or write-through types
// [RULE17] memory-type override replaces incoming type with the attribute field
// [RULE18] bypass attributes apply only while disabled; missing incoming gets a default
// [RULE19] absent override capabilities make fields act as keep incoming
// [RULE20] transactions after update completes use the new attributes
// [RULE21] write during update in progress is ignored
// [RULE22] reads return newly written bypass value at once
// [RULE23] aborted transactions get an error response and are not forwarded
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "bypass_regs_defs.vh"

module iommu_cr2_bypass_attr_regs #(
  parameter TYPE_OVR_CAP = 1,
  parameter PERM_OVR_CAP = 1,
  parameter BCAST_MAINT_CAP = 1
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // incoming client transaction
  input wire in_valid,
  input wire in_write,
  input wire in_instr,
  input wire in_priv,
  input wire [1:0] in_share,
  input wire in_share_present,
  input wire [3:0] in_mtype,
  input wire in_mtype_present,
  input wire [2:0] in_alloc,
  input wire in_bad_stream_id,
  input wire in_secure,
  // broadcast maintenance in
  input wire bcast_inv_valid,
  // outgoing transaction
  output wire out_valid,
  output wire out_instr,
  output wire out_priv,
  output wire [1:0] out_share,
  output wire [3:0] out_mtype,
  output wire [2:0] out_alloc,
  output wire out_translate,
  output wire out_tag_asid,
  output wire in_error,
  output wire bad_stream_id_event,
  output wire local_tlb_invalidate
);

  // ------------------------------------------------
  // bus address phase capture
  // ------------------------------------------------
  reg wr_pend_ff;
  reg rd_pend_ff;
  reg [`ADDR_W-1:0] addr_ff;
  reg [31:0] rdata_ff;
  wire take = hsel & hready & (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);

  // ------------------------------------------------
  // register state
  // ------------------------------------------------
  reg [2:0] ctl_two_ff;
  reg [2:0] ctl_two_eff_ff;
  reg [31:0] bypass_ff;
  reg [31:0] bypass_eff_ff;
  reg update_ff;
  reg [2:0] upd_cnt_ff;
  reg enable_req_ff;
  reg enable_ack_ff;
  reg [2:0] en_cnt_ff;

  wire en_busy = enable_req_ff != enable_ack_ff;
  wire wr_ctl_two = wr_pend_ff & (addr_ff == `OFS_CONTROL_TWO);
  wire wr_bypass = wr_pend_ff & (addr_ff == `OFS_BYPASS_ATTR);
  wire wr_ctl_zero = wr_pend_ff & (addr_ff == `OFS_CONTROL_ZERO);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= {`ADDR_W{1'b0}};
    end else begin
      wr_pend_ff <= take & hwrite;
      rd_pend_ff <= take & ~hwrite;
      if (take) begin
        addr_ff <= haddr[`ADDR_W-1:0];
      end
    end
  end

  // ------------------------------------------------
  // control_two and translation enable
  // ------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_two_ff <= `CT_RESET;
      ctl_two_eff_ff <= `CT_RESET;
      enable_req_ff <= 1'b0;
      enable_ack_ff <= 1'b0;
      en_cnt_ff <= 3'h0;
    end else begin
      // writes while enabled are dropped; while the enable is settling they still apply
      if (wr_ctl_two && !enable_ack_ff) begin // RULE6 RULE7
        ctl_two_ff[`CT_PRIV_MAINT] <= (BCAST_MAINT_CAP != 0) ? hwdata[`CT_PRIV_MAINT] : 1'b0;
        ctl_two_ff[`CT_BAD_SID_REC] <= hwdata[`CT_BAD_SID_REC];
        ctl_two_ff[`CT_HOST_EXT] <= hwdata[`CT_HOST_EXT];
      end
      if (wr_ctl_zero) begin
        enable_req_ff <= hwdata[`C0_ENABLE];
      end
      if (en_busy) begin
        if (en_cnt_ff == `ENABLE_CYCLES - 3'h1) begin
          en_cnt_ff <= 3'h0;
          enable_ack_ff <= enable_req_ff;
          // the effective copy lands at enable completion at the latest
          if (enable_req_ff) begin
            ctl_two_eff_ff <= ctl_two_ff; // RULE8 RULE9
          end
        end else begin
          en_cnt_ff <= en_cnt_ff + 3'h1;
        end
      end else begin
        en_cnt_ff <= 3'h0;
        if (!enable_ack_ff) begin
          ctl_two_eff_ff <= ctl_two_ff; // RULE8
        end
      end
    end
  end

  // ------------------------------------------------
  // global_bypass_attributes with update handshake
  // ------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bypass_ff <= `BA_RESET;
      bypass_eff_ff <= `BA_RESET;
      update_ff <= 1'b0;
      upd_cnt_ff <= 3'h0;
    end else begin
      // a write without the update bit, or during an update, is ignored
      if (wr_bypass && !update_ff && hwdata[`BA_UPDATE]) begin // RULE11 RULE21
        bypass_ff <= hwdata & `BA_MASK; // RULE22
        update_ff <= 1'b1;
        upd_cnt_ff <= 3'h0;
      end else if (update_ff) begin
        if (upd_cnt_ff == `UPDATE_CYCLES - 3'h1) begin
          bypass_eff_ff <= bypass_ff; // RULE20
          update_ff <= 1'b0; // RULE11
        end else begin
          upd_cnt_ff <= upd_cnt_ff + 3'h1;
        end
      end
    end
  end

  // ------------------------------------------------
  // read data
  // ------------------------------------------------
  reg [31:0] rd_mux;
  always @* begin
    case (haddr[`ADDR_W-1:0])
      `OFS_CONTROL_TWO: rd_mux = {29'h0, ctl_two_ff};
      `OFS_BYPASS_ATTR: rd_mux = {update_ff, bypass_ff[30:0]}; // RULE22
      `OFS_CONTROL_ZERO: rd_mux = {31'h0, enable_req_ff};
      `OFS_STATUS: rd_mux = {30'h0, update_ff, enable_ack_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      rdata_ff <= rd_mux;
    end
  end

  assign hrdata = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ------------------------------------------------
  // transaction attribute path
  // ------------------------------------------------
  wire [31:0] ba = bypass_eff_ff;
  wire bypass_on = ~enable_ack_ff & ~in_secure; // RULE18
  wire [1:0] inst_f = (PERM_OVR_CAP != 0) ? ba[`BA_INST_HI:`BA_INST_LO] : `OVR_INCOMING; // RULE19
  wire [1:0] priv_f = (PERM_OVR_CAP != 0) ? ba[`BA_PRIV_HI:`BA_PRIV_LO] : `OVR_INCOMING;
  wire [1:0] sh_f = (TYPE_OVR_CAP != 0) ? ba[`BA_SH_HI:`BA_SH_LO] : `SH_INCOMING;
  wire [3:0] al_f = (TYPE_OVR_CAP != 0) ? ba[`BA_ALLOC_HI:`BA_ALLOC_LO] : 4'h0;
  wire mt_ovr = (TYPE_OVR_CAP != 0) & ba[`BA_MTYPE_OVR];
  // interconnect without an attribute gets a fixed default
  wire [3:0] mt_in = in_mtype_present ? in_mtype : `MT_NC_DEFAULT; // RULE18
  wire [1:0] sh_in = in_share_present ? in_share : `SH_DEFAULT; // RULE18

  reg o_instr;
  reg o_priv;
  reg [1:0] o_share;
  reg [3:0] o_mtype;
  reg [2:0] o_alloc;
  always @* begin
    o_instr = in_instr;
    o_priv = in_priv;
    o_share = in_share;
    o_mtype = in_mtype;
    o_alloc = in_alloc;
    if (bypass_on) begin
      case (inst_f) // RULE13
        `OVR_FORCE_LO: o_instr = 1'b0;
        `OVR_FORCE_HI: o_instr = 1'b1;
        default: o_instr = in_instr;
      endcase
      if (in_write) begin
        o_instr = 1'b0; // RULE13
      end
      case (priv_f) // RULE13
        `OVR_FORCE_LO: o_priv = 1'b0;
        `OVR_FORCE_HI: o_priv = 1'b1;
        default: o_priv = in_priv;
      endcase
      case (sh_f) // RULE14
        `SH_INCOMING: o_share = sh_in;
        default: o_share = sh_f;
      endcase
      o_mtype = mt_ovr ? ba[`BA_MATTR_HI:`BA_MATTR_LO] : mt_in; // RULE17
      // hints cannot be expressed for device or non-cacheable types
      if (al_f[3] && (o_mtype == `MT_NORMAL_WB || o_mtype == `MT_NORMAL_WT)) begin // RULE16
        o_alloc = al_f[2:0]; // RULE15
      end
    end
  end

  wire abort = bypass_on & ba[`BA_ABORT]; // RULE12
  assign out_valid = in_valid & ~abort; // RULE23
  assign in_error = in_valid & abort; // RULE23
  assign out_instr = o_instr;
  assign out_priv = o_priv;
  assign out_share = o_share;
  assign out_mtype = o_mtype;
  assign out_alloc = o_alloc;
  assign out_translate = in_valid & ~bypass_on;
  assign out_tag_asid = ctl_two_eff_ff[`CT_HOST_EXT]; // RULE4
  assign bad_stream_id_event = in_valid & in_bad_stream_id & enable_ack_ff
    & ctl_two_eff_ff[`CT_BAD_SID_REC]; // RULE2 RULE3
  assign local_tlb_invalidate = bcast_inv_valid & enable_ack_ff
    & ~ctl_two_eff_ff[`CT_PRIV_MAINT]; // RULE1 RULE9

endmodule

// ==== design/bypass_regs_defs.vh ====
`ifndef BYPASS_REGS_DEFS_VH
`define BYPASS_REGS_DEFS_VH

// --------------------------------------------------
// register byte offsets
// --------------------------------------------------
`define OFS_CONTROL_TWO 8'h00
`define OFS_BYPASS_ATTR 8'h04
`define OFS_CONTROL_ZERO 8'h08
`define OFS_STATUS 8'h0c
`define ADDR_W 8

// --------------------------------------------------
// control_two fields
// --------------------------------------------------
`define CT_PRIV_MAINT 2
`define CT_BAD_SID_REC 1
`define CT_HOST_EXT 0
`define CT_MASK 32'h0000_0007
// private maintenance set out of reset, the other fields clear
`define CT_RESET 3'h4

// --------------------------------------------------
// global_bypass_attributes fields
// --------------------------------------------------
`define BA_UPDATE 31
`define BA_ABORT 20
`define BA_INST_HI 19
`define BA_INST_LO 18
`define BA_PRIV_HI 17
`define BA_PRIV_LO 16
`define BA_SH_HI 13
`define BA_SH_LO 12
`define BA_ALLOC_HI 11
`define BA_ALLOC_LO 8
`define BA_MTYPE_OVR 4
`define BA_MATTR_HI 3
`define BA_MATTR_LO 0
`define BA_MASK 32'h001f_3f1f
`define BA_RESET 32'h0010_0000

// --------------------------------------------------
// control_zero / status fields
// --------------------------------------------------
`define C0_ENABLE 0
`define ST_ENABLE_ACK 0
`define ST_UPDATE_BUSY 1

// --------------------------------------------------
// attribute encodings and timing
// --------------------------------------------------
`define OVR_INCOMING 2'b00
`define OVR_RSVD 2'b01
`define OVR_FORCE_LO 2'b10
`define OVR_FORCE_HI 2'b11
`define SH_NON 2'b00
`define SH_INCOMING 2'b01
`define MT_NORMAL_WB 4'hf
`define MT_NORMAL_WT 4'ha
`define MT_NC_DEFAULT 4'h0
`define SH_DEFAULT 2'b10
`define UPDATE_CYCLES 3'h4
`define ENABLE_CYCLES 3'h4

`define HTRANS_NONSEQ 2'b10
`define HTRANS_SEQ 2'b11

`endif

// ==== test/bypass_regs_chk.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the bypass register block
// ----------------------------------------
module bypass_regs_chk (
  // bus
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  // client transaction
  input wire in_valid,
  input wire in_write,
  input wire in_secure,
  input wire in_bad_stream_id,
  input wire [2:0] in_alloc,
  input wire bcast_inv_valid,
  input wire out_valid,
  input wire out_instr,
  input wire [3:0] out_mtype,
  input wire [2:0] out_alloc,
  input wire out_translate,
  input wire in_error,
  input wire bad_stream_id_event,
  input wire local_tlb_invalidate
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_byp;
    in_valid && !out_translate;
  endsequence
  sequence s_rd;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  property p_drop;
    in_error |-> in_valid && !out_valid && !out_translate;
  endproperty
  property p_fwd;
    s_byp ##0 !in_error |-> out_valid;
  endproperty
  property p_wr;
    s_byp ##0 in_write && out_valid |-> !out_instr;
  endproperty
  property p_evt;
    bad_stream_id_event |-> in_valid && in_bad_stream_id && out_translate;
  endproperty
  property p_inv;
    local_tlb_invalidate |-> bcast_inv_valid;
  endproperty
  property p_sec;
    in_valid && in_secure |-> out_translate && !in_error;
  endproperty
  // hints only make sense for cacheable normal memory
  property p_alloc;
    s_byp ##0 out_valid && out_mtype != 4'hf && out_mtype != 4'ha |-> out_alloc == in_alloc;
  endproperty
  property p_hold;
    s_rd ##1 !(hsel && htrans[1]) |=> $stable(hrdata);
  endproperty
  a_drop: assert property (p_drop) else $error("aborted transaction forwarded");
  a_fwd: assert property (p_fwd) else $error("bypass transaction lost");
  a_wr: assert property (p_wr) else $error("write left as instruction");
  a_evt: assert property (p_evt) else $error("stray bad stream event");
  a_inv: assert property (p_inv) else $error("invalidate without broadcast");
  a_sec: assert property (p_sec) else $error("secure stream bypassed");
  a_alloc: assert property (p_alloc) else $error("hints changed on uncached type");
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule

// ==== test/client_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// client device traffic on the interconnect
// ----------------------------------------
module client_model (
  // clock
  input wire hclk,
  // transaction
  output logic in_valid,
  output logic [15:0] attr
);
  initial begin
    in_valid = 1'b0;
    attr = 16'h0;
  end
  task automatic start(input logic [15:0] a);
    @(posedge hclk);
    in_valid <= 1'b1;
    attr <= a;
  endtask
  // released lines invert so stale attributes cannot pass for fresh ones
  task automatic stop;
    @(posedge hclk);
    in_valid <= 1'b0;
    attr <= ~attr;
  endtask
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// register and bypass bench
// ----------------------------------------
module tb;
  logic hclk, hresetn, hsel, hwrite, bcast, ie;
  logic [1:0] htrans, c;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, q;
  wire [31:0] hrdata;
  wire hreadyout, hresp, in_valid, inv;
  wire [15:0] at, ob;
  wire hready = hreadyout;
  int err_total, samples_checked;
  client_model cm_i (.hclk(hclk), .in_valid(in_valid), .attr(at));
  iommu_cr2_bypass_attr_regs iommu_cr2_bypass_attr_regs_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .in_valid(in_valid), .in_write(at[15]),
    .in_instr(at[14]), .in_priv(at[13]), .in_share(at[12:11]), .in_share_present(at[10]),
    .in_mtype(at[9:6]), .in_mtype_present(at[5]), .in_alloc(at[4:2]),
    .in_bad_stream_id(at[1]), .in_secure(at[0]), .bcast_inv_valid(bcast),
    .out_valid(ob[13]), .out_instr(ob[12]), .out_priv(ob[11]), .out_share(ob[10:9]),
    .out_mtype(ob[8:5]), .out_alloc(ob[4:2]), .out_translate(ob[1]), .out_tag_asid(ob[15]),
    .in_error(ob[0]), .bad_stream_id_event(ob[14]), .local_tlb_invalidate(inv));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic stop_test;
    $display("compared %0d mismatched %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (n >= 64) begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
    chk("response", 32'h0, {31'h0, hresp});
  endtask
  // status poll is bounded so a stuck flag ends the run
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      bus(1'b0, 8'h0c, 32'h0);
      n++;
    end while (q[b] !== v && n < 32);
    if (n >= 32) begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic xa(input logic [15:0] a, input logic [15:0] e, input logic [15:0] m);
    cm_i.start(a);
    #1;
    chk("transaction", {16'h0, e & m}, {16'h0, ob & m});
    cm_i.stop();
  endtask
  task automatic bc(input logic e);
    @(posedge hclk);
    bcast <= 1'b1;
    #1;
    chk("invalidate", {31'h0, e}, {31'h0, inv});
    @(posedge hclk);
    bcast <= 1'b0;
  endtask
  initial begin
    {hresetn, hsel, hwrite, bcast, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    err_total = 0;
    samples_checked = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h00, 32'h4);
    rd(8'h04, 32'h0010_0000);
    rd(8'h10, 32'h0);
    xa(16'h0002, 16'h0001, 16'hc003);
    $display("reset test done");
    bus(1'b1, 8'h04, 32'h800e_3d1f);
    bus(1'b1, 8'h04, 32'h8010_0000);
    rd(8'h04, 32'h800e_3d1f);
    poll(1, 1'b0);
    bus(1'b1, 8'h04, 32'h0010_0000);
    rd(8'h04, 32'h000e_3d1f);
    xa(16'h2d60, 16'h37f4, 16'hffff);
    xa(16'had60, 16'h27f4, 16'hffff);
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      ie = c[1] ? c[0] : 1'b1;
      bus(1'b1, 8'h04, {1'b1, 11'h0, c, c, 2'h0, c, 4'hf, 3'h0, c[0], 4'h0});
      poll(1, 1'b0);
      xa({3'h3, 2'h3, 1'b1, 4'hf, c[1], 3'h2, 2'h0}, {3'h1, ie, ie, (c == 2'h1) ? 2'h3 : c,
        (c[0] | !c[1]) ? 4'h0 : 4'hf, (c == 2'h2) ? 3'h7 : 3'h2, 2'h0}, 16'hffff);
    end
    $display("bypass test done");
    bus(1'b1, 8'h00, 32'h3);
    bus(1'b1, 8'h08, 32'h1);
    poll(0, 1'b1);
    bus(1'b1, 8'h00, 32'h4);
    rd(8'h00, 32'h3);
    xa(16'h2d62, 16'hc002, 16'hc003);
    bc(1'b1);
    $display("enable test done");
    bus(1'b1, 8'h08, 32'h0);
    poll(0, 1'b0);
    bus(1'b1, 8'h00, 32'h4);
    bus(1'b1, 8'h08, 32'h1);
    poll(0, 1'b1);
    xa(16'h2d62, 16'h0002, 16'hc003);
    bc(1'b0);
    $display("reprogram test done");
    stop_test();
  end
endmodule
bind iommu_cr2_bypass_attr_regs bypass_regs_chk bypass_regs_chk_i (.*);
